// ---- rtl/fifo_pm_pkg.sv ----
package fifo_pm_pkg;
  // ------------------------------
  // Register map
  // ------------------------------
  localparam logic [7:0] ADDR_RX_FIFO_OCCUPANCY = 8'h18;
  localparam logic [7:0] ADDR_TX_FIFO_VACANCY = 8'h1C;
  localparam logic [7:0] ADDR_POWER_MANAGEMENT_CONTROL = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADDR_WAKE_STATE = 8'h2C;

  // ------------------------------
  // Field positions and resets
  // ------------------------------
  localparam int BIT_CLR_STS = 9;
  localparam int BIT_CLR_EN = 8;
  localparam int BIT_READY = 7;
  localparam int BIT_SUSP_LO = 5;
  localparam int BIT_LITE_RST = 3;
  localparam logic [15:0] RX_USED_RESET = 16'h0000;
  localparam logic [15:0] TX_FREE_RESET = 16'h2000;
  localparam logic [1:0] SUSP_DEFAULT = 2'h2;
  localparam logic CLR_STS_RESET = 1'h0;
  localparam logic CLR_EN_RESET = 1'h1;
  localparam logic [15:0] WORD_ROUND = 16'h0003;
  localparam logic [15:0] WORD_MASK = 16'hFFFC;

  // Wake status bits (own layout): 0 frame,1 pattern,2 perfect,3 bcast
  localparam int NUM_WAKE_STS = 4;
  // Wake state word: enables low, status from bit 8, event flag at bit 12
  localparam int BIT_WAKE_STS_LO = 8;
  localparam int BIT_WAKE_EVT = 12;
  // Wake enables: 0..4 excluded from auto clear, 5..7 others
  localparam int NUM_WAKE_EN = 8;
  localparam logic [7:0] EN_KEEP_MASK = 8'h1F;
  localparam int NUM_IRQ = 3;
  localparam int IRQ_READY = 0;
  localparam int IRQ_RESUME = 1;
  localparam int IRQ_DECONF = 2;

  // Lite reset sequence length in cycles
  localparam logic [7:0] LITE_RST_CYCLES = 8'h10;

  typedef enum logic [1:0]
  {
    PWR_UNCONF = 2'b00,
    PWR_INIT = 2'b01,
    PWR_CONF = 2'b11,
    PWR_LITE = 2'b10
  } pwr_state_t;
endpackage : fifo_pm_pkg

// ---- rtl/fifo_count_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Occupancy update lines toward the counter
interface fifo_count_if;
  logic rxAdd;
  logic [15:0] rxAddBytes;
  logic rxRemove;
  logic [15:0] rxRemoveBytes;
  logic txPush;
  logic [15:0] txPushBytes;
  logic txPop;
  logic [15:0] txPopBytes;
  logic [15:0] rxUsed;
  logic [15:0] txFree;
  modport ctrl (output rxAdd, rxAddBytes, rxRemove, rxRemoveBytes, txPush, txPushBytes, txPop, txPopBytes,
    input rxUsed, txFree);
  modport cnt (input rxAdd, rxAddBytes, rxRemove, rxRemoveBytes, txPush, txPushBytes, txPop, txPopBytes,
    output rxUsed, txFree);
endinterface : fifo_count_if
`default_nettype wire

// ---- rtl/fifo_level_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_level_counter
  import fifo_pm_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rst, // Sync reset, active high
  input wire logic liteRst, // Lite reset pulse
  fifo_count_if.cnt cnt // Count updates
);
  logic [15:0] rxUsed_reg, rxUsed_next;
  logic [15:0] txFree_reg, txFree_next;

  // Round a length up to whole 32-bit words
  function automatic logic [15:0] roundWord(input logic [15:0] len);
    roundWord = (len + WORD_ROUND) & WORD_MASK;
  endfunction : roundWord

  // ------------------------------
  // Counters
  // ------------------------------
  always_comb
  begin
    rxUsed_next = rxUsed_reg;
    txFree_next = txFree_reg;
    if (cnt.rxAdd)
      rxUsed_next = rxUsed_next + roundWord(cnt.rxAddBytes); // R02
    if (cnt.rxRemove)
      rxUsed_next = rxUsed_next - roundWord(cnt.rxRemoveBytes);
    if (cnt.txPush)
      txFree_next = txFree_next - roundWord(cnt.txPushBytes);
    if (cnt.txPop)
      txFree_next = txFree_next + roundWord(cnt.txPopBytes);
    if (liteRst)
    begin
      rxUsed_next = RX_USED_RESET; // Lite reset empties both FIFOs
      txFree_next = TX_FREE_RESET;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rxUsed_reg <= RX_USED_RESET; // R01
      txFree_reg <= TX_FREE_RESET; // R03
    end
    else
    begin
      rxUsed_reg <= rxUsed_next;
      txFree_reg <= txFree_next;
    end
  end

  assign cnt.rxUsed = rxUsed_reg;
  assign cnt.txFree = txFree_reg;
endmodule : fifo_level_counter
`default_nettype wire

// ---- rtl/fifo_level_and_power_mgmt_regs.sv ----
// Contract
// R01 - RX used bytes, 16 bits, reset zero
// R02 - Add frame length rounded to words
// R03 - TX free bytes, reset 8192
// R04 - Resume clears four wake status flags
// R05 - Resume also clears wake event status bit1
// R06 - Control clear keeps status; resets 0
// R07 - Remote-wake resume clears enables; reset 1
// R08 - Host resume never clears enables
// R09 - Five global wake enables are kept
// R10 - Ready only normal and configured done
// R11 - Ready waits watchdog without PHY clocks
// R12 - Suspend select 2 bits, reset 10
// R13 - Deconfigure forces select to 10
// R14 - Software picks only level 2 unconfigured; the code accepts any select written in every state
// R15 - Codes 00..11 map suspend 0..3
// R16 - Lite reset local, bit self clears
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module fifo_level_and_power_mgmt_regs
  import fifo_pm_pkg::*;
(
  input wire logic clk_sys, // System clock 10 MHz
  input wire logic rst, // Sync reset, active high
  input wire logic [7:0] regAddr, // Register byte address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [31:0] regRdata, // Read data, cycle after strobe
  output logic irq, // Level interrupt
  input wire logic rxAdd, // Frame written into RX FIFO
  input wire logic [15:0] rxAddBytes, // Its length in bytes
  input wire logic rxRemove, // Data read out of RX FIFO
  input wire logic [15:0] rxRemoveBytes, // Bytes read out
  input wire logic txPush, // Data written into TX FIFO
  input wire logic [15:0] txPushBytes, // Bytes written
  input wire logic txPop, // Data sent from TX FIFO
  input wire logic [15:0] txPopBytes, // Bytes sent
  input wire logic configured, // Host set configuration
  input wire logic deconfigure, // Deconfigure event pulse
  input wire logic initDone, // Hardware configuration finished
  input wire logic phyClkPresent, // PHY clocks running
  input wire logic resumeDone, // Resume sequence completed pulse
  input wire logic resumeRemote, // Resume started by remote wake
  input wire logic [3:0] wakeStsSet, // Wake status events
  input wire logic wakeEventSet, // Wake event status bit1 set
  output logic [3:0] suspendLevel, // One-hot suspend level 0..3
  output logic liteResetActive // Lite reset in progress
);
  parameter int WDOG_CYCLES = 1000; // Ready watchdog without PHY clocks

  logic resumeClrSts_reg, resumeClrSts_next;
  logic resumeClrEn_reg, resumeClrEn_next;
  logic [1:0] suspSel_reg, suspSel_next;
  logic [NUM_WAKE_STS-1:0] wakeSts_reg, wakeSts_next;
  logic wakeEvt_reg, wakeEvt_next;
  logic [NUM_WAKE_EN-1:0] wakeEn_reg, wakeEn_next;
  logic [NUM_IRQ-1:0] irqSts_reg, irqSts_next;
  logic [NUM_IRQ-1:0] irqMask_reg, irqMask_next;
  logic [31:0] rdata_reg, rdata_next;
  pwr_state_t state_reg, state_next;
  logic [7:0] liteCnt_reg, liteCnt_next;
  logic [31:0] wdog_reg, wdog_next;
  logic ready_reg, ready_next;
  logic [3:0] suspLevel_reg, suspLevel_next;
  logic liteActive_reg, liteActive_next;
  logic liteStart;
  logic liteEnd;
  logic wrPmt;

  fifo_count_if cntIf ();

  // Updates go straight through; rounding is in the counter
  assign cntIf.rxAdd = rxAdd;
  assign cntIf.rxAddBytes = rxAddBytes;
  assign cntIf.rxRemove = rxRemove;
  assign cntIf.rxRemoveBytes = rxRemoveBytes;
  assign cntIf.txPush = txPush;
  assign cntIf.txPushBytes = txPushBytes;
  assign cntIf.txPop = txPop;
  assign cntIf.txPopBytes = txPopBytes;

  fifo_level_counter counter
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .liteRst(liteStart),
    .cnt(cntIf.cnt)
  );

  // ------------------------------
  // Power state machine
  // ------------------------------
  // One strobe aimed at one register address
  function automatic logic regHit(input logic strobe, input logic [7:0] addr, input logic [7:0] target);
    regHit = strobe && (addr == target);
  endfunction : regHit

  assign wrPmt = regHit(regWr, regAddr, ADDR_POWER_MANAGEMENT_CONTROL);
  // Ignore a new lite reset while one is running
  assign liteStart = wrPmt && regWdata[BIT_LITE_RST] && (state_reg != PWR_LITE);
  assign liteEnd = (state_reg == PWR_LITE) && (liteCnt_reg == 8'h00);

  // Only local state is touched by lite reset; USB side untouched
  always_comb
  begin
    state_next = state_reg;
    liteCnt_next = liteCnt_reg;
    wdog_next = wdog_reg;
    case (state_reg)
      PWR_UNCONF:
      begin
        if (configured)
        begin
          state_next = PWR_INIT;
          wdog_next = WDOG_CYCLES;
        end
      end
      PWR_INIT:
      begin
        if (wdog_reg != 32'h0)
          wdog_next = wdog_reg - 32'h1;
        if (initDone && (phyClkPresent || wdog_reg == 32'h0)) // R11
          state_next = PWR_CONF;
      end
      PWR_CONF:
      begin
      end
      PWR_LITE:
      begin
        if (liteCnt_reg != 8'h00)
          liteCnt_next = liteCnt_reg - 8'h01;
        if (wdog_reg != 32'h0)
          wdog_next = wdog_reg - 32'h1;
        if (liteEnd && (phyClkPresent || wdog_reg == 32'h0)) // R11 R16
          state_next = configured ? PWR_CONF : PWR_UNCONF;
      end
      default:
        state_next = PWR_UNCONF;
    endcase
    if (liteStart)
    begin
      state_next = PWR_LITE;
      liteCnt_next = LITE_RST_CYCLES;
      wdog_next = WDOG_CYCLES;
    end
    if (deconfigure)
      state_next = PWR_UNCONF; // R13
    // Busy flag registered so the pin comes from a flip-flop
    liteActive_next = (state_next == PWR_LITE); // R16
  end

  // State registers; reset is synchronous
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= PWR_UNCONF;
      liteCnt_reg <= 8'h00;
      wdog_reg <= 32'h0;
      liteActive_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      liteCnt_reg <= liteCnt_next;
      wdog_reg <= wdog_next;
      liteActive_reg <= liteActive_next;
    end
  end

  // ------------------------------
  // Control and wake bits
  // ------------------------------
  // Ready means configured normal state with setup done
  always_comb
  begin
    ready_next = (state_next == PWR_CONF) && initDone; // R10
    resumeClrSts_next = resumeClrSts_reg;
    resumeClrEn_next = resumeClrEn_reg;
    suspSel_next = suspSel_reg;
    wakeEn_next = wakeEn_reg;
    wakeSts_next = wakeSts_reg;
    wakeEvt_next = wakeEvt_reg;
    if (wrPmt)
    begin
      resumeClrSts_next = regWdata[BIT_CLR_STS]; // R06
      resumeClrEn_next = regWdata[BIT_CLR_EN]; // R07
      suspSel_next = regWdata[BIT_SUSP_LO +: $bits(suspSel_reg)]; // R12
    end
    if (regHit(regWr, regAddr, ADDR_WAKE_STATE))
      wakeEn_next = regWdata[NUM_WAKE_EN-1:0];
    // Resume clearing; status set below wins over it
    if (resumeDone && resumeClrSts_reg)
    begin
      wakeSts_next = '0; // R04
      wakeEvt_next = 1'b0; // R05
    end
    if (resumeDone && resumeRemote && resumeClrEn_reg) // R07 R08
      wakeEn_next = wakeEn_next & EN_KEEP_MASK; // R09
    wakeSts_next = wakeSts_next | wakeStsSet;
    wakeEvt_next = wakeEvt_next | wakeEventSet;
    if (deconfigure)
      suspSel_next = SUSP_DEFAULT; // R13
    // Decode the next select so the one-hot pins come from flip-flops
    suspLevel_next = '0;
    suspLevel_next[suspSel_next] = 1'b1; // R15
  end

  // Control registers; reset gives the field defaults
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ready_reg <= 1'b0;
      resumeClrSts_reg <= CLR_STS_RESET;
      resumeClrEn_reg <= CLR_EN_RESET;
      suspSel_reg <= SUSP_DEFAULT;
      wakeEn_reg <= '0;
      wakeSts_reg <= '0;
      wakeEvt_reg <= 1'b0;
      suspLevel_reg <= 4'h1 << SUSP_DEFAULT;
    end
    else
    begin
      ready_reg <= ready_next;
      resumeClrSts_reg <= resumeClrSts_next;
      resumeClrEn_reg <= resumeClrEn_next;
      suspSel_reg <= suspSel_next;
      wakeEn_reg <= wakeEn_next;
      wakeSts_reg <= wakeSts_next;
      wakeEvt_reg <= wakeEvt_next;
      suspLevel_reg <= suspLevel_next;
    end
  end

  // Status pins straight from their flip-flops
  assign suspendLevel = suspLevel_reg; // R15
  assign liteResetActive = liteActive_reg; // R16

  // ------------------------------
  // Interrupts and read port
  // ------------------------------
  // Sticky events; a new event beats the read that clears
  always_comb
  begin
    irqMask_next = irqMask_reg;
    irqSts_next = irqSts_reg;
    if (regHit(regRd, regAddr, ADDR_IRQ_STATUS))
      irqSts_next = '0;
    if (regHit(regWr, regAddr, ADDR_IRQ_MASK))
      irqMask_next = regWdata[NUM_IRQ-1:0];
    irqSts_next[IRQ_READY] = irqSts_next[IRQ_READY] | (ready_next & ~ready_reg);
    irqSts_next[IRQ_RESUME] = irqSts_next[IRQ_RESUME] | resumeDone;
    irqSts_next[IRQ_DECONF] = irqSts_next[IRQ_DECONF] | deconfigure;
  end

  // Read mux; unmapped addresses return zero
  always_comb
  begin
    rdata_next = 32'h0;
    if (regRd)
    begin
      case (regAddr)
        ADDR_RX_FIFO_OCCUPANCY: rdata_next[15:0] = cntIf.rxUsed; // R01
        ADDR_TX_FIFO_VACANCY: rdata_next[15:0] = cntIf.txFree; // R03
        ADDR_POWER_MANAGEMENT_CONTROL:
        begin
          rdata_next[BIT_CLR_STS] = resumeClrSts_reg;
          rdata_next[BIT_CLR_EN] = resumeClrEn_reg;
          rdata_next[BIT_READY] = ready_reg; // R10
          rdata_next[BIT_SUSP_LO +: $bits(suspSel_reg)] = suspSel_reg;
          rdata_next[BIT_LITE_RST] = (state_reg == PWR_LITE); // R16
        end
        ADDR_IRQ_STATUS: rdata_next[NUM_IRQ-1:0] = irqSts_reg;
        ADDR_IRQ_MASK: rdata_next[NUM_IRQ-1:0] = irqMask_reg;
        ADDR_WAKE_STATE:
        begin
          rdata_next[NUM_WAKE_EN-1:0] = wakeEn_reg;
          rdata_next[BIT_WAKE_STS_LO +: NUM_WAKE_STS] = wakeSts_reg;
          rdata_next[BIT_WAKE_EVT] = wakeEvt_reg;
        end
        default: rdata_next = 32'h0;
      endcase
    end
  end

  // Interrupt and read data registers
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      irqSts_reg <= '0;
      irqMask_reg <= '0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      irqSts_reg <= irqSts_next;
      irqMask_reg <= irqMask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign regRdata = rdata_reg;
  assign irq = |(irqSts_reg & irqMask_reg);
endmodule : fifo_level_and_power_mgmt_regs
`default_nettype wire

// ---- dv/fifo_level_and_power_mgmt_regs_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_pm_checker
  import fifo_pm_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] regAddr, // Address
  input wire logic [31:0] regWdata, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  input wire logic [31:0] regRdata, // Read data
  input wire logic deconfigure, // Deconfigure
  input wire logic initDone, // Init done
  input wire logic [3:0] suspendLevel, // Suspend level
  input wire logic liteResetActive // Lite reset busy
);
  // ----------
  // Properties
  // ----------
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_idle_zero;
    !regRd |=> regRdata == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data not zero when idle");
  property p_rx_upper;
    regRd && regAddr == ADDR_RX_FIFO_OCCUPANCY |=> regRdata[31:16] == 16'h0;
  endproperty
  a_rx_upper: assert property (p_rx_upper)
    else $error("rx occupancy upper half not zero");
  property p_tx_upper;
    regRd && regAddr == ADDR_TX_FIFO_VACANCY |=> regRdata[31:16] == 16'h0;
  endproperty
  a_tx_upper: assert property (p_tx_upper)
    else $error("tx vacancy upper half not zero");
  property p_deconf;
    deconfigure |=> suspendLevel == 4'h4;
  endproperty
  a_deconf: assert property (p_deconf)
    else $error("deconfigure did not select level 2");
  property p_map;
    regRd && regAddr == ADDR_POWER_MANAGEMENT_CONTROL && !deconfigure |=> suspendLevel == (4'h1 << regRdata[6:5]);
  endproperty
  a_map: assert property (p_map)
    else $error("suspend level does not match select field");
  // Two low samples so a registered ready has settled
  property p_ready;
    (!initDone) [*2] ##0 (regRd && regAddr == ADDR_POWER_MANAGEMENT_CONTROL) |=> !regRdata[BIT_READY];
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready set without finished init");
  property p_lite_go;
    regWr && regAddr == ADDR_POWER_MANAGEMENT_CONTROL && regWdata[BIT_LITE_RST] && !deconfigure && !liteResetActive
      |=> liteResetActive;
  endproperty
  a_lite_go: assert property (p_lite_go)
    else $error("lite reset did not start");
  property p_lite_end;
    $rose(liteResetActive) |-> liteResetActive [*8] ##[1:1000] !liteResetActive;
  endproperty
  a_lite_end: assert property (p_lite_end)
    else $error("lite reset length wrong");
endmodule : fifo_pm_checker

bind fifo_level_and_power_mgmt_regs fifo_pm_checker fifo_pm_checker_inst (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .deconfigure(deconfigure), .initDone(initDone), .suspendLevel(suspendLevel),
  .liteResetActive(liteResetActive)
);
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
  import fifo_pm_pkg::*;
;
  localparam logic [7:0] PM = ADDR_POWER_MANAGEMENT_CONTROL;
  logic clk_sys, rst, regWr, regRd, irq, liteResetActive, rxAdd, rxRemove, txPush, txPop;
  logic configured, deconfigure, initDone, phyClkPresent, resumeDone, resumeRemote, wakeEventSet;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, rdv;
  logic [15:0] rxAddBytes, rxRemoveBytes, txPushBytes, txPopBytes;
  logic [3:0] wakeStsSet, suspendLevel;
  int n_fail = 0, checked = 0, cycles = 0;

  fifo_level_and_power_mgmt_regs #(.WDOG_CYCLES(20)) fifo_level_and_power_mgmt_regs_inst (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq), .rxAdd(rxAdd), .rxAddBytes(rxAddBytes), .rxRemove(rxRemove),
    .rxRemoveBytes(rxRemoveBytes), .txPush(txPush), .txPushBytes(txPushBytes), .txPop(txPop),
    .txPopBytes(txPopBytes), .configured(configured), .deconfigure(deconfigure), .initDone(initDone),
    .phyClkPresent(phyClkPresent), .resumeDone(resumeDone), .resumeRemote(resumeRemote),
    .wakeStsSet(wakeStsSet), .wakeEventSet(wakeEventSet), .suspendLevel(suspendLevel),
    .liteResetActive(liteResetActive));

  // ---------------
  // Clock and guard
  // ---------------
  initial
  begin
    clk_sys = 1'h0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Tests need about 180 cycles; a hang stops here
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_fail++;
      results();
    end
  end

  // ----------
  // Bus tasks
  // ----------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'h1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask : wr
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1 rdv = regRdata;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk($sformatf("reg %h", a), exp, rdv);
  endtask : rdc
  task automatic fifo(input logic [3:0] op, input logic [15:0] n);
    @(posedge clk_sys);
    {txPop, txPush, rxRemove, rxAdd} <= op;
    {rxAddBytes, rxRemoveBytes, txPushBytes, txPopBytes} <= {4{n}};
    @(posedge clk_sys);
    {txPop, txPush, rxRemove, rxAdd} <= 4'h0;
  endtask : fifo
  // Bits: wake event, wake status 3:0, resume done, deconfigure
  task automatic pulse(input logic [6:0] p);
    @(posedge clk_sys);
    {wakeEventSet, wakeStsSet, resumeDone, deconfigure} <= p;
    @(posedge clk_sys);
    {wakeEventSet, wakeStsSet, resumeDone, deconfigure} <= 7'h0;
  endtask : pulse

  // ---------
  // Scenarios
  // ---------
  task automatic t_reset();
    rdc(ADDR_RX_FIFO_OCCUPANCY, 32'h0);
    rdc(ADDR_TX_FIFO_VACANCY, 32'h2000);
    rdc(PM, 32'h140);
    wr(ADDR_RX_FIFO_OCCUPANCY, 32'hFFFF);
    rdc(ADDR_RX_FIFO_OCCUPANCY, 32'h0);
    rdc(8'h40, 32'h0);
    chk("suspendLevel", 32'h4, {28'h0, suspendLevel});
    $display("reset test done");
  endtask : t_reset
  task automatic t_fifo();
    fifo(4'h1, 16'h5);
    fifo(4'h1, 16'h8);
    rdc(ADDR_RX_FIFO_OCCUPANCY, 32'h10);
    fifo(4'h4, 16'h6);
    rdc(ADDR_TX_FIFO_VACANCY, 32'h1FF8);
    fifo(4'hA, 16'h8);
    rdc(ADDR_RX_FIFO_OCCUPANCY, 32'h8);
    rdc(ADDR_TX_FIFO_VACANCY, 32'h2000);
    $display("fifo test done");
  endtask : t_fifo
  task automatic t_susp();
    @(posedge clk_sys);
    configured <= 1'h1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 4; i++)
    begin
      wr(PM, {22'h0, 2'h1, 1'h0, i[1:0], 5'h0});
      rd(PM);
      chk("suspendSelect", 32'(i), {30'h0, rdv[6:5]});
      chk("suspendLevel", 32'h1 << i, {28'h0, suspendLevel});
    end
    pulse(7'h1);
    #1 chk("suspendLevel", 32'h4, {28'h0, suspendLevel});
    $display("suspend test done");
  endtask : t_susp
  task automatic t_ready();
    repeat (5) @(posedge clk_sys);
    rd(PM);
    chk("ready", 32'h1, {31'h0, rdv[7]});
    @(posedge clk_sys);
    phyClkPresent <= 1'h0;
    pulse(7'h1);
    repeat (10) @(posedge clk_sys);
    rd(PM);
    chk("ready", 32'h0, {31'h0, rdv[7]});
    repeat (40) @(posedge clk_sys);
    rd(PM);
    chk("ready", 32'h1, {31'h0, rdv[7]});
    @(posedge clk_sys);
    initDone <= 1'h0;
    rd(PM);
    chk("ready", 32'h0, {31'h0, rdv[7]});
    @(posedge clk_sys);
    initDone <= 1'h1;
    phyClkPresent <= 1'h1;
    $display("ready test done");
  endtask : t_ready
  task automatic t_irq();
    rd(ADDR_IRQ_STATUS);
    wr(ADDR_IRQ_MASK, 32'h4);
    pulse(7'h1);
    #1 chk("irq", 32'h1, {31'h0, irq});
    rd(ADDR_IRQ_STATUS);
    chk("irqStatus", 32'h4, rdv & 32'h4);
    chk("irq", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0);
    pulse(7'h1);
    #1 chk("irq", 32'h0, {31'h0, irq});
    $display("irq test done");
  endtask : t_irq
  task automatic t_resume();
    wr(ADDR_WAKE_STATE, 32'hFF);
    pulse(7'h7C);
    resumeRemote <= 1'h0;
    pulse(7'h2);
    rdc(ADDR_WAKE_STATE, 32'h1FFF);
    wr(PM, 32'h340);
    pulse(7'h2);
    rdc(ADDR_WAKE_STATE, 32'hFF);
    pulse(7'h7C);
    resumeRemote <= 1'h1;
    pulse(7'h2);
    rdc(ADDR_WAKE_STATE, 32'h1F);
    $display("resume test done");
  endtask : t_resume
  task automatic t_lite();
    fifo(4'h1, 16'h4);
    wr(PM, 32'h148);
    rd(PM);
    chk("liteBit", 32'h1, {31'h0, rdv[3]});
    for (int i = 0; i < 100 && liteResetActive; i++) @(posedge clk_sys);
    #1 chk("liteResetActive", 32'h0, {31'h0, liteResetActive});
    rdc(ADDR_RX_FIFO_OCCUPANCY, 32'h0);
    rd(PM);
    chk("liteBit", 32'h0, {31'h0, rdv[3]});
    $display("lite reset test done");
  endtask : t_lite

  task automatic results();
    $display("Checked %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // Reset for two cycles, then run every scenario
  initial
  begin
    rst = 1'h1;
    {regWr, regRd, rxAdd, rxRemove, txPush, txPop, configured, deconfigure} = 8'h0;
    {resumeDone, resumeRemote, wakeEventSet, initDone, phyClkPresent} = 5'h3;
    {regAddr, regWdata, rxAddBytes, rxRemoveBytes, txPushBytes, txPopBytes, wakeStsSet} = 108'h0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset();
    t_fifo();
    t_susp();
    t_ready();
    t_irq();
    t_resume();
    t_lite();
    results();
  end
endmodule : tb
`default_nettype wire
